// ===== shared/dtap_regs.svh
// Notes on behaviour
// [R1] sample serial inputs only on enabled edges; chain_data_out samples debug_serial_in on every edge
// [R2] decode 0010 select, 1100 test, 1110 id
// [R3] select register captures 1000 under select
// [R4] update-DR select value picks active chain
// [R5] reset makes chain 0 active
// [R6] select register four bits, lsb first
// [R7] internal test: test mode, chain in path
// [R8] id read: capture fixed code, shift out
// [R9] id code fixed, no parallel output
// [R10] bypass bit captures zero, one-cycle delay
// [R11] 1111 and unassigned codes act as bypass
// [R12] 0100 bypass path, resume on idle entry
// [R13] instruction register captures 0001, lsb first
// [R14] new instruction takes effect at update-IR
// [R15] reset selects identification-read instruction
// [R16] selected register shifts once per enabled cycle
// [R17] chain 1 debug, 2 breakpoint, others reserved
// [R18] reserved chain shifts out zeros only
// [R19] host pulses port reset low before use
// [R20] instruction register four bits, no parity
// [R21] host gives one-cycle enables, synchronous inputs
`ifndef DTAP_REGS_SVH
`define DTAP_REGS_SVH

`define DTAP_IR_WIDTH 4
`define DTAP_SEL_WIDTH 4
`define DTAP_ID_WIDTH 32
`define DTAP_OP_SCAN_SEL 4'h2
`define DTAP_OP_INT_TEST 4'hc
`define DTAP_OP_ID_READ 4'he
`define DTAP_OP_BYPASS 4'hf
`define DTAP_OP_RESUME 4'h4
`define DTAP_IR_CAPTURE 4'h1
`define DTAP_SEL_CAPTURE 4'h8
`define DTAP_SEL_RESET 4'h0
`define DTAP_BYP_CAPTURE 1'h0
`define DTAP_CHAIN_DEBUG 4'h1
`define DTAP_CHAIN_BKPT 4'h2
// arbitrary identity value, not tied to any real part
`define DTAP_ID_DEFAULT 32'h5a3c_0001
// state numbers shown on the state output
`define DTAP_SC_RESET 4'hf
`define DTAP_SC_IDLE 4'hc
`define DTAP_SC_SEL_DR 4'h7
`define DTAP_SC_CAP_DR 4'h6
`define DTAP_SC_SHIFT_DR 4'h2
`define DTAP_SC_EX1_DR 4'h1
`define DTAP_SC_PAUSE_DR 4'h3
`define DTAP_SC_EX2_DR 4'h0
`define DTAP_SC_UPD_DR 4'h5
`define DTAP_SC_SEL_IR 4'h4
`define DTAP_SC_CAP_IR 4'he
`define DTAP_SC_SHIFT_IR 4'ha
`define DTAP_SC_EX1_IR 4'h9
`define DTAP_SC_PAUSE_IR 4'hb
`define DTAP_SC_EX2_IR 4'h8
`define DTAP_SC_UPD_IR 4'hd

`endif

// ===== shared/dtap_pkg.sv
`include "dtap_regs.svh"

package dtap_pkg;

	typedef enum logic [3:0] {
		st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_ex1_dr, st_pause_dr, st_ex2_dr,
		st_upd_dr, st_sel_ir, st_cap_ir, st_shift_ir, st_ex1_ir, st_pause_ir, st_ex2_ir, st_upd_ir
	} dtap_state_t;

	typedef enum logic [1:0] {
		path_bypass, path_ident, path_select, path_chain
	} dtap_path_t;

	// data register picked by an instruction code
	function automatic dtap_path_t dtap_path(input logic [3:0] code);
		case (code)
			`DTAP_OP_SCAN_SEL: dtap_path = path_select;
			`DTAP_OP_INT_TEST: dtap_path = path_chain;
			`DTAP_OP_ID_READ: dtap_path = path_ident;
			default: dtap_path = path_bypass;
		endcase
	endfunction

endpackage

// ===== verilog/dtap_shift.sv
`timescale 1ns/1ps

// capture and shift register, lsb leaves first
module dtap_shift
	import dtap_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input wire logic core_clk_in,
	input wire logic clear_n_in,
	input wire logic [WIDTH-1:0] clear_value_in,
	input wire logic capture_in,
	input wire logic shift_in,
	input wire logic serial_in,
	input wire logic [WIDTH-1:0] capture_value_in,
	output logic [WIDTH-1:0] data_out
);

	logic [WIDTH-1:0] data_q;
	logic [WIDTH-1:0] data_d;

	// next value: capture, shift toward bit 0, or hold
	always_comb begin
		data_d = data_q;
		if (capture_in) begin
			data_d = capture_value_in;
		end else if (shift_in) begin
			// new bit enters at the top, also for one bit
			data_d = data_q >> 1;
			data_d[WIDTH-1] = serial_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!clear_n_in) begin
			data_q <= clear_value_in;
		end else begin
			data_q <= data_d;
		end
	end

	assign data_out = data_q;

endmodule

// ===== verilog/dtap_chain_mux.sv
`timescale 1ns/1ps

`include "dtap_regs.svh"

// serial output of the active scan chain
module dtap_chain_mux
	import dtap_pkg::*;
(
	input wire logic [3:0] chain_in,
	input wire logic debug_sdo_in,
	input wire logic bkpt_sdo_in,
	output logic serial_out
);

	// [R17] chain number allocation
	// [R18] reserved chains give zeros
	always_comb begin
		case (chain_in)
			`DTAP_CHAIN_DEBUG: serial_out = debug_sdo_in;
			`DTAP_CHAIN_BKPT: serial_out = bkpt_sdo_in;
			default: serial_out = 1'h0;
		endcase
	end

endmodule

// ===== verilog/dtap_instr.sv
`timescale 1ns/1ps

`include "dtap_regs.svh"

// debug test port: controller, instruction and data registers
module dtap_instr
	import dtap_pkg::*;
#(
	parameter logic [31:0] ID_CODE = `DTAP_ID_DEFAULT
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic debug_port_reset_n_in,
	input wire logic debug_clock_enable_in,
	input wire logic debug_serial_in,
	input wire logic debug_mode_select_in,
	input wire logic chain_debug_sdo_in,
	input wire logic chain_bkpt_sdo_in,
	output logic debug_serial_out,
	output logic [3:0] tap_state_out,
	output logic [3:0] current_instr_out,
	output logic [3:0] active_chain_out,
	output logic test_mode_out,
	output logic chain_capture_out,
	output logic chain_shift_out,
	output logic chain_update_out,
	output logic chain_data_out,
	output logic resume_out
);

	logic rst_any;
	logic en;
	dtap_state_t state_q;
	dtap_state_t state_d;
	dtap_state_t prev_state_q;
	logic [3:0] instr_q;
	logic [3:0] instr_d;
	logic [3:0] chain_q;
	logic [3:0] chain_d;
	dtap_path_t path;
	logic [3:0] ir_data;
	logic [3:0] sel_data;
	logic [31:0] id_data;
	logic byp_data;
	logic chain_sdo;
	logic out_d;
	logic test_mode_d;
	logic cap_d;
	logic shf_d;
	logic upd_d;
	logic resume_d;
	logic [3:0] state_code;

	// either reset clears the port logic
	assign rst_any = !rst_n_in || !debug_port_reset_n_in;
	// [R1] controller and register steps gated by enable
	assign en = debug_clock_enable_in;
	// [R2] [R11] decode current instruction
	assign path = dtap_path(instr_q);

	// state number shown to the outside
	function automatic logic [3:0] dtap_code(input dtap_state_t s);
		case (s)
			st_reset: dtap_code = `DTAP_SC_RESET;
			st_idle: dtap_code = `DTAP_SC_IDLE;
			st_sel_dr: dtap_code = `DTAP_SC_SEL_DR;
			st_cap_dr: dtap_code = `DTAP_SC_CAP_DR;
			st_shift_dr: dtap_code = `DTAP_SC_SHIFT_DR;
			st_ex1_dr: dtap_code = `DTAP_SC_EX1_DR;
			st_pause_dr: dtap_code = `DTAP_SC_PAUSE_DR;
			st_ex2_dr: dtap_code = `DTAP_SC_EX2_DR;
			st_upd_dr: dtap_code = `DTAP_SC_UPD_DR;
			st_sel_ir: dtap_code = `DTAP_SC_SEL_IR;
			st_cap_ir: dtap_code = `DTAP_SC_CAP_IR;
			st_shift_ir: dtap_code = `DTAP_SC_SHIFT_IR;
			st_ex1_ir: dtap_code = `DTAP_SC_EX1_IR;
			st_pause_ir: dtap_code = `DTAP_SC_PAUSE_IR;
			st_ex2_ir: dtap_code = `DTAP_SC_EX2_IR;
			st_upd_ir: dtap_code = `DTAP_SC_UPD_IR;
			default: dtap_code = `DTAP_SC_RESET;
		endcase
	endfunction

	// [R1] controller moves on enabled edges only
	always_comb begin
		state_d = state_q;
		if (en) begin
			case (state_q)
				st_reset: state_d = debug_mode_select_in ? st_reset : st_idle;
				st_idle: state_d = debug_mode_select_in ? st_sel_dr : st_idle;
				st_sel_dr: state_d = debug_mode_select_in ? st_sel_ir : st_cap_dr;
				st_cap_dr: state_d = debug_mode_select_in ? st_ex1_dr : st_shift_dr;
				st_shift_dr: state_d = debug_mode_select_in ? st_ex1_dr : st_shift_dr;
				st_ex1_dr: state_d = debug_mode_select_in ? st_upd_dr : st_pause_dr;
				st_pause_dr: state_d = debug_mode_select_in ? st_ex2_dr : st_pause_dr;
				st_ex2_dr: state_d = debug_mode_select_in ? st_upd_dr : st_shift_dr;
				st_upd_dr: state_d = debug_mode_select_in ? st_sel_dr : st_idle;
				st_sel_ir: state_d = debug_mode_select_in ? st_reset : st_cap_ir;
				st_cap_ir: state_d = debug_mode_select_in ? st_ex1_ir : st_shift_ir;
				st_shift_ir: state_d = debug_mode_select_in ? st_ex1_ir : st_shift_ir;
				st_ex1_ir: state_d = debug_mode_select_in ? st_upd_ir : st_pause_ir;
				st_pause_ir: state_d = debug_mode_select_in ? st_ex2_ir : st_pause_ir;
				st_ex2_ir: state_d = debug_mode_select_in ? st_upd_ir : st_shift_ir;
				st_upd_ir: state_d = debug_mode_select_in ? st_sel_dr : st_idle;
				default: state_d = st_reset;
			endcase
		end
	end

	// instruction register, four bits, captures 0001
	// [R13] capture and lsb-first shift
	// [R20] four bits, no parity
	dtap_shift #(
		.WIDTH(`DTAP_IR_WIDTH)
	) u_ir (
		.core_clk_in(core_clk_in),
		.clear_n_in(!rst_any),
		.clear_value_in(`DTAP_IR_CAPTURE),
		.capture_in(en && state_q == st_cap_ir),
		.shift_in(en && state_q == st_shift_ir),
		.serial_in(debug_serial_in),
		.capture_value_in(`DTAP_IR_CAPTURE),
		.data_out(ir_data)
	);

	// [R3] select register captures 1000
	// [R6] four bits, lsb first
	dtap_shift #(
		.WIDTH(`DTAP_SEL_WIDTH)
	) u_sel (
		.core_clk_in(core_clk_in),
		.clear_n_in(!rst_any),
		.clear_value_in(`DTAP_SEL_CAPTURE),
		.capture_in(en && state_q == st_cap_dr && path == path_select),
		.shift_in(en && state_q == st_shift_dr && path == path_select),
		.serial_in(debug_serial_in),
		.capture_value_in(`DTAP_SEL_CAPTURE),
		.data_out(sel_data)
	);

	// [R8] identity captured in capture-DR
	// [R9] fixed code, serial access only
	dtap_shift #(
		.WIDTH(`DTAP_ID_WIDTH)
	) u_id (
		.core_clk_in(core_clk_in),
		.clear_n_in(!rst_any),
		.clear_value_in(ID_CODE),
		.capture_in(en && state_q == st_cap_dr && path == path_ident),
		.shift_in(en && state_q == st_shift_dr && path == path_ident),
		.serial_in(debug_serial_in),
		.capture_value_in(ID_CODE),
		.data_out(id_data)
	);

	// [R10] bypass bit captures zero
	// [R12] resume code uses the bypass bit
	dtap_shift #(
		.WIDTH(1)
	) u_byp (
		.core_clk_in(core_clk_in),
		.clear_n_in(!rst_any),
		.clear_value_in(`DTAP_BYP_CAPTURE),
		.capture_in(en && state_q == st_cap_dr && path == path_bypass),
		.shift_in(en && state_q == st_shift_dr && path == path_bypass),
		.serial_in(debug_serial_in),
		.capture_value_in(`DTAP_BYP_CAPTURE),
		.data_out(byp_data)
	);

	dtap_chain_mux u_mux (
		.chain_in(chain_q),
		.debug_sdo_in(chain_debug_sdo_in),
		.bkpt_sdo_in(chain_bkpt_sdo_in),
		.serial_out(chain_sdo)
	);

	// current instruction and active chain
	always_comb begin
		instr_d = instr_q;
		chain_d = chain_q;
		if (en && state_q == st_reset) begin
			instr_d = `DTAP_OP_ID_READ;
			chain_d = `DTAP_SEL_RESET;
		end else if (en && state_q == st_upd_ir) begin
			// [R14] shifted code takes effect
			instr_d = ir_data;
		end else if (en && state_q == st_upd_dr && path == path_select) begin
			// [R4] select value names active chain
			chain_d = sel_data;
		end
	end

	// serial output source and chain strobes
	always_comb begin
		out_d = 1'h0;
		if (state_q == st_shift_ir) begin
			out_d = ir_data[0];
		end else if (state_q == st_shift_dr) begin
			// [R16] bit 0 of the selected register
			case (path)
				path_select: out_d = sel_data[0];
				path_ident: out_d = id_data[0];
				path_chain: out_d = chain_sdo;
				default: out_d = byp_data;
			endcase
		end
		// [R7] test mode and chain steps
		test_mode_d = path == path_chain;
		cap_d = en && state_q == st_cap_dr && path == path_chain;
		shf_d = en && state_q == st_shift_dr && path == path_chain;
		upd_d = en && state_q == st_upd_dr && path == path_chain;
		// [R12] resume on first cycle in idle
		resume_d = instr_q == `DTAP_OP_RESUME && state_q == st_idle && prev_state_q != st_idle;
	end

	// state, instruction and chain registers
	always_ff @(posedge core_clk_in) begin
		if (rst_any) begin
			state_q <= st_reset;
			prev_state_q <= st_reset;
			// [R15] reset selects identity read
			instr_q <= `DTAP_OP_ID_READ;
			// [R5] reset selects chain 0
			chain_q <= `DTAP_SEL_RESET;
		end else begin
			state_q <= state_d;
			prev_state_q <= state_q;
			instr_q <= instr_d;
			chain_q <= chain_d;
		end
	end

	assign state_code = dtap_code(state_q);

	// registered outputs
	always_ff @(posedge core_clk_in) begin
		if (rst_any) begin
			debug_serial_out <= 1'h0;
			tap_state_out <= `DTAP_SC_RESET;
			current_instr_out <= `DTAP_OP_ID_READ;
			active_chain_out <= `DTAP_SEL_RESET;
			test_mode_out <= 1'h0;
			chain_capture_out <= 1'h0;
			chain_shift_out <= 1'h0;
			chain_update_out <= 1'h0;
			chain_data_out <= 1'h0;
			resume_out <= 1'h0;
		end else begin
			debug_serial_out <= out_d;
			tap_state_out <= state_code;
			current_instr_out <= instr_q;
			active_chain_out <= chain_q;
			test_mode_out <= test_mode_d;
			chain_capture_out <= cap_d;
			chain_shift_out <= shf_d;
			chain_update_out <= upd_d;
			chain_data_out <= debug_serial_in;
			resume_out <= resume_d;
		end
	end

	property p_gate_enable;
		@(posedge core_clk_in) disable iff (rst_any)
		!en |=> $stable(state_q) && $stable(ir_data) && $stable(byp_data);
	endproperty
	a_gate_enable: assert property (p_gate_enable) else $error("port moved without enable"); // [R1]

	property p_decode;
		@(posedge core_clk_in) disable iff (rst_any)
		(instr_q == 4'hc) |-> ##2 test_mode_out || $past(rst_any) || $past(instr_q) != 4'hc;
	endproperty
	a_decode: assert property (p_decode) else $error("internal test code not decoded"); // [R2]

	property p_sel_capture;
		@(posedge core_clk_in) disable iff (rst_any)
		en && state_q == st_cap_dr && instr_q == 4'h2 |=> sel_data == 4'h8;
	endproperty
	a_sel_capture: assert property (p_sel_capture) else $error("select register capture wrong"); // [R3]

	property p_sel_shift;
		@(posedge core_clk_in) disable iff (rst_any)
		en && state_q == st_shift_dr && path == path_select
			|=> sel_data == {$past(debug_serial_in), $past(sel_data[3:1])};
	endproperty
	a_sel_shift: assert property (p_sel_shift) else $error("select shift wrong"); // [R6]

	property p_chain_hold;
		@(posedge core_clk_in) disable iff (rst_any)
		!(en && state_q inside {st_upd_dr, st_reset}) |=> $stable(chain_q);
	endproperty
	a_chain_hold: assert property (p_chain_hold) else $error("active chain changed"); // [R4]

	property p_chain_reset;
		@(posedge core_clk_in)
		!rst_n_in |=> chain_q == 4'h0 ##1 active_chain_out == 4'h0 || rst_any;
	endproperty
	a_chain_reset: assert property (p_chain_reset) else $error("reset chain not zero"); // [R5]

	property p_id_capture;
		@(posedge core_clk_in) disable iff (rst_any)
		en && state_q == st_cap_dr && instr_q == 4'he |=> id_data == ID_CODE;
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("identity not captured"); // [R8]

	property p_bypass_delay;
		@(posedge core_clk_in) disable iff (rst_any)
		en && state_q == st_shift_dr && path == path_bypass |=> byp_data == $past(debug_serial_in);
	endproperty
	a_bypass_delay: assert property (p_bypass_delay) else $error("bypass delay wrong"); // [R10]

	property p_unassigned;
		@(posedge core_clk_in) disable iff (rst_any)
		state_q == st_shift_dr && !(instr_q inside {4'h2, 4'hc, 4'he}) |=> debug_serial_out == $past(byp_data);
	endproperty
	a_unassigned: assert property (p_unassigned) else $error("unassigned code not bypass"); // [R11]

	property p_resume;
		@(posedge core_clk_in) disable iff (rst_any)
		instr_q == 4'h4 && state_q == st_idle && prev_state_q != st_idle |=> resume_out;
	endproperty
	a_resume: assert property (p_resume) else $error("resume pulse missing"); // [R12]

	property p_ir_shift;
		@(posedge core_clk_in) disable iff (rst_any)
		en && state_q == st_shift_ir |=> ir_data == {$past(debug_serial_in), $past(ir_data[3:1])};
	endproperty
	a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong"); // [R13]

	property p_instr_hold;
		@(posedge core_clk_in) disable iff (rst_any)
		!(en && state_q inside {st_upd_ir, st_reset}) |=> $stable(instr_q);
	endproperty
	a_instr_hold: assert property (p_instr_hold) else $error("instruction changed early"); // [R14]

	property p_instr_reset;
		@(posedge core_clk_in)
		!debug_port_reset_n_in |=> instr_q == 4'he;
	endproperty
	a_instr_reset: assert property (p_instr_reset) else $error("reset instruction wrong"); // [R15]

	property p_reserved_zero;
		@(posedge core_clk_in) disable iff (rst_any)
		state_q == st_shift_dr && path == path_chain && !(chain_q inside {4'h1, 4'h2}) |=> !debug_serial_out;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved chain not zero"); // [R18]

endmodule

// ===== sim/dtap_host.sv
`timescale 1ns/1ps

// external debug host: paced enables, lsb-first scans
module dtap_host (
	input wire logic core_clk_in,
	input wire logic serial_from_dut_in,
	output logic port_reset_n_out,
	output logic clock_enable_out,
	output logic serial_to_dut_out,
	output logic mode_select_out,
	output logic done_out,
	output logic [31:0] result_out
);
	int seed = 32'h8efdbe9e;

	// port reset driven low, then high
	initial begin
		port_reset_n_out = 1'b0;
		clock_enable_out = 1'b0;
		serial_to_dut_out = 1'b0;
		mode_select_out = 1'b1;
		done_out = 1'b0;
		result_out = '0;
		repeat (20) @(negedge core_clk_in);
		port_reset_n_out = 1'b1;
	end

	// one enabled cycle, then a noisy gap
	task automatic step(input logic mode, input logic data, output logic seen);
		@(negedge core_clk_in);
		seen = serial_from_dut_in;
		clock_enable_out = 1'b1;
		mode_select_out = mode;
		serial_to_dut_out = data;
		@(negedge core_clk_in);
		clock_enable_out = 1'b0;
		mode_select_out = 1'($random(seed));
		serial_to_dut_out = 1'($random(seed));
	endtask

	// idle to shift, move len bits, update, back to idle
	task automatic scan(input logic is_ir, input int len, input logic [31:0] din);
		logic seen;
		logic [31:0] got;
		got = '0;
		step(1'b1, 1'b0, seen);
		if (is_ir)
			step(1'b1, 1'b0, seen);
		step(1'b0, 1'b0, seen);
		step(1'b0, 1'b0, seen);
		for (int i = 0; i < len; i++) begin
			step(i == len - 1, din[i], seen);
			got[i] = seen;
		end
		step(1'b1, 1'b0, seen);
		step(1'b0, 1'b0, seen);
		@(negedge core_clk_in);
		done_out = 1'b1;
		result_out = got;
		@(negedge core_clk_in);
		done_out = 1'b0;
	endtask
endmodule

// ===== sim/test_debug_tap_instruction_logic.sv
`timescale 1ns/1ps

module test_debug_tap_instruction_logic;
	import dtap_pkg::*;

	// arbitrary identity value for this run
	localparam logic [31:0] ID_TEST = 32'h1234_5a5a;

	logic core_clk_in;
	logic rst_n_in;
	logic port_reset_n, clock_enable, serial_in, mode_select, done;
	logic [31:0] result;
	logic debug_sdo, bkpt_sdo, seen;
	logic debug_serial_out, test_mode_out, chain_capture_out, chain_shift_out, chain_update_out, resume_out;
	logic chain_data_out;
	logic [31:0] shf_bits;
	logic [3:0] tap_state_out, current_instr_out, active_chain_out, code;
	int err_count = 0;
	int checks_done = 0;
	int seed = 32'h8efdbe9e;
	int cap_cnt, shf_cnt, upd_cnt, res_cnt;
	logic [31:0] exp_q[$];
	logic [31:0] data;
	logic [3:0] chains [4] = '{4'h1, 4'h2, 4'h0, 4'h3};
	logic [3:0] codes [4] = '{4'hf, 4'h4, 4'h0, 4'h9};

	dtap_instr #(.ID_CODE(ID_TEST)) dut (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.debug_port_reset_n_in(port_reset_n),
		.debug_clock_enable_in(clock_enable),
		.debug_serial_in(serial_in),
		.debug_mode_select_in(mode_select),
		.chain_debug_sdo_in(debug_sdo),
		.chain_bkpt_sdo_in(bkpt_sdo),
		.debug_serial_out(debug_serial_out),
		.tap_state_out(tap_state_out),
		.current_instr_out(current_instr_out),
		.active_chain_out(active_chain_out),
		.test_mode_out(test_mode_out),
		.chain_capture_out(chain_capture_out),
		.chain_shift_out(chain_shift_out),
		.chain_update_out(chain_update_out),
		.chain_data_out(chain_data_out),
		.resume_out(resume_out)
	);

	dtap_host host (
		.core_clk_in(core_clk_in),
		.serial_from_dut_in(debug_serial_out),
		.port_reset_n_out(port_reset_n),
		.clock_enable_out(clock_enable),
		.serial_to_dut_out(serial_in),
		.mode_select_out(mode_select),
		.done_out(done),
		.result_out(result)
	);

	// free-running core clock
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	task automatic give_verdict();
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic compare_scan(input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t scan got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic compare_val(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_state(input logic [3:0] instr, input logic [3:0] chain);
		compare_val("instr", current_instr_out, instr);
		compare_val("chain", active_chain_out, chain);
	endtask

	// note the expected word, then let the host scan
	task automatic run_scan(input logic is_ir, input int len, input logic [31:0] din, input logic [31:0] exp);
		exp_q.push_back(exp);
		host.scan(is_ir, len, din);
		@(negedge core_clk_in);
	endtask

	// result watcher: oldest note against each finished scan
	always @(posedge core_clk_in) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("MISMATCH %0t unexpected scan result", $time);
			end else begin
				// one bit per enabled shift cycle
				compare_scan(exp_q.pop_front(), result);
			end
		end
	end

	// count chain strobes and resume pulses
	always @(posedge core_clk_in) begin
		cap_cnt += int'(chain_capture_out === 1'b1);
		shf_cnt += int'(chain_shift_out === 1'b1);
		upd_cnt += int'(chain_update_out === 1'b1);
		res_cnt += int'(resume_out === 1'b1);
		// collect chain data bits seen with each shift pulse
		if (chain_shift_out === 1'b1)
			shf_bits = {chain_data_out, shf_bits[31:1]};
	end

	// hang guard
	initial begin
		repeat (60000) @(posedge core_clk_in);
		err_count++;
		$display("MISMATCH %0t run timed out", $time);
		give_verdict();
	end

	initial begin
		rst_n_in = 1'b0;
		debug_sdo = 1'b0;
		bkpt_sdo = 1'b0;
		cap_cnt = 0;
		shf_cnt = 0;
		upd_cnt = 0;
		res_cnt = 0;
		repeat (20) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		check_state(4'he, 4'h0);
		compare_val("state", tap_state_out, 4'hf);
		host.step(1'b0, 1'b0, seen);
		data = $random(seed);
		run_scan(1'b0, 32, data, ID_TEST);
		check_state(4'he, 4'h0);
		// select each chain, then scan it under internal test
		for (int k = 0; k < 4; k++) begin
			run_scan(1'b1, 4, 32'h2, 32'h1);
			compare_val("instr", current_instr_out, 4'h2);
			run_scan(1'b0, 4, {28'h0, chains[k]}, 32'h8);
			compare_val("chain", active_chain_out, chains[k]);
			run_scan(1'b1, 4, 32'hc, 32'h1);
			compare_val("test mode", test_mode_out, 1'b1);
			compare_val("chain", active_chain_out, chains[k]);
			debug_sdo = (chains[k] != 4'h2);
			bkpt_sdo = (chains[k] != 4'h1);
			cap_cnt = 0;
			shf_cnt = 0;
			upd_cnt = 0;
			shf_bits = '0;
			data = $random(seed);
			run_scan(1'b0, 6, data, (chains[k] inside {4'h1, 4'h2}) ? 32'h3f : 32'h0);
			compare_val("strobes", {8'h0, cap_cnt[7:0], shf_cnt[7:0], upd_cnt[7:0]}, 32'h010601);
			compare_val("chain data", {26'h0, shf_bits[31:26]}, {26'h0, data[5:0]});
		end
		// bypass, resume and unassigned codes
		for (int k = 0; k < 4; k++) begin
			code = codes[k];
			if (k == 3) begin
				code = 4'($random(seed));
				if (code inside {4'h2, 4'h4, 4'hc, 4'he, 4'hf})
					code = 4'h9;
			end
			res_cnt = 0;
			run_scan(1'b1, 4, {28'h0, code}, 32'h1);
			compare_val("instr", current_instr_out, code);
			compare_val("test mode", test_mode_out, 1'b0);
			data = $random(seed);
			run_scan(1'b0, 8, data, {24'h0, data[6:0], 1'b0});
			compare_val("resume", res_cnt, (code == 4'h4) ? 32'h2 : 32'h0);
			compare_val("chain", active_chain_out, 4'h3);
		end
		// second reset in mid-run
		rst_n_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		check_state(4'he, 4'h0);
		host.step(1'b0, 1'b0, seen);
		run_scan(1'b0, 32, 32'h0, ID_TEST);
		if (exp_q.size() != 0) begin
			err_count++;
			$display("MISMATCH %0t scan results missing", $time);
		end
		give_verdict();
	end
endmodule
